// [src/rcb_map.svh]
// constants for the reference clock pad buffer block
// assumes inclusion by the package and design files; definitions only
`ifndef RCB_MAP_SVH
`define RCB_MAP_SVH

// group geometry
`define RCB_NUM_CHAN     4
`define RCB_NUM_PAIR     2
`define RCB_SEL_W        2

// fabric clock output configuration codes
`define RCB_FAB_PASS     2'h0
`define RCB_FAB_DIV2     2'h1
`define RCB_FAB_ZERO     2'h2
`define RCB_FAB_RSVD     2'h3

// pad drive path setting expected per direction
`define RCB_DRIVE_IN     1'h0
`define RCB_DRIVE_OUT    1'h1

// reset values
`define RCB_SEL_RESET    2'h0

`endif

// [src/rcb_pkg.sv]
// types shared by the reference clock pad buffer design
// assumes rcb_map.svh is on the include path
`include "rcb_map.svh"

package rcb_pkg;

  // direction of a pad pair, fixed when the design is built
  typedef enum logic {
    RCB_MODE_INPUT  = 1'b0,
    RCB_MODE_OUTPUT = 1'b1
  } rcb_mode_e;

  // divide-by-two phase, gray along the toggle path
  typedef enum logic {
    RCB_DIV_LOW  = 1'b0,
    RCB_DIV_HIGH = 1'b1
  } rcb_div_e;

  // static settings of one pad buffer
  typedef struct packed {
    logic                  buffer_enable_n;
    logic [`RCB_SEL_W-1:0] fabric_out_config;
    logic                  pad_drive_path_cfg;
  } rcb_pair_cfg_s;

  // differential pad pair seen from the core
  typedef struct packed {
    logic pos;
    logic neg;
  } rcb_pad_s;

endpackage

// [src/rcb_chan_mux.sv]
// recovered clock selector of one output buffer, registered
// assumes recovered clocks already sampled in the mclk domain
`timescale 1ns/100ps
`include "rcb_map.svh"

module rcb_chan_mux (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     resetn,
  // channel clocks and choice
  input  wire logic [`RCB_NUM_CHAN-1:0] recovered_rx_clock,
  input  wire logic [`RCB_SEL_W-1:0]    buffer_channel_select,
  // forwarded clock
  output logic                          chosen_clock
);

  logic next_chosen_clock;

  // one-hot decode of the channel index
  function automatic logic [`RCB_NUM_CHAN-1:0] chan_onehot(input logic [`RCB_SEL_W-1:0] idx);
    chan_onehot = `RCB_NUM_CHAN'(1) << idx;
  endfunction

  always_comb begin
    next_chosen_clock = 1'b0;
    if (resetn) begin
      next_chosen_clock = |(recovered_rx_clock & chan_onehot(buffer_channel_select));
    end
  end

  // register keeps the output glitch free across select changes
  always_ff @(posedge mclk) begin
    chosen_clock <= next_chosen_clock;
  end

  a_mux_index: assert property (@(posedge mclk) disable iff (!resetn)
    $past(resetn) |-> chosen_clock == $past(recovered_rx_clock[buffer_channel_select]))
    else $error("mux output does not follow selected channel");

endmodule

// [src/rcb_top.sv]
// reference clock pad buffers of a four-channel transceiver group
// assumes pad and recovered clocks are sampled synchronously to mclk
`timescale 1ns/100ps
`include "rcb_map.svh"

module rcb_top #(
  parameter rcb_pkg::rcb_mode_e          PAIR_A_MODE = rcb_pkg::RCB_MODE_INPUT,
  parameter rcb_pkg::rcb_mode_e          PAIR_B_MODE = rcb_pkg::RCB_MODE_OUTPUT,
  parameter bit                          PAIR_A_SELECTABLE = 1'b1,
  parameter bit                          PAIR_B_SELECTABLE = 1'b1,
  parameter logic [`RCB_SEL_W-1:0]       PAIR_A_FIXED_CHAN = 2'h0,
  parameter logic [`RCB_SEL_W-1:0]       PAIR_B_FIXED_CHAN = 2'h0
) (
  // clock and reset
  input  wire logic                       mclk,
  input  wire logic                       resetn,
  // static buffer settings, one per pad pair
  input  wire rcb_pkg::rcb_pair_cfg_s     pair_a_cfg,
  input  wire rcb_pkg::rcb_pair_cfg_s     pair_b_cfg,
  // common block select requests
  input  wire logic [`RCB_SEL_W-1:0]      pair0_select_request,
  input  wire logic [`RCB_SEL_W-1:0]      pair1_select_request,
  // channel recovered clocks
  input  wire logic [`RCB_NUM_CHAN-1:0]   recovered_rx_clock,
  // pad pair a
  input  wire logic                       pad_a_positive_in,
  input  wire logic                       pad_a_negative_in,
  output logic                            pad_a_positive_out,
  output logic                            pad_a_negative_out,
  output logic                            pad_a_oe,
  // pad pair b
  input  wire logic                       pad_b_positive_in,
  input  wire logic                       pad_b_negative_in,
  output logic                            pad_b_positive_out,
  output logic                            pad_b_negative_out,
  output logic                            pad_b_oe,
  // clocks toward the core
  output logic                            local_ref_clock_a,
  output logic                            local_ref_clock_b,
  output logic [`RCB_NUM_PAIR-1:0]        fabric_clock_out,
  // common block select outputs
  output logic [`RCB_SEL_W-1:0]           pad_pair0_channel_select,
  output logic [`RCB_SEL_W-1:0]           pad_pair1_channel_select,
  // setting mismatch per pair
  output logic [`RCB_NUM_PAIR-1:0]        cfg_error
);

  // per-pair views of ports
  rcb_pkg::rcb_pair_cfg_s                 cfg      [`RCB_NUM_PAIR];
  rcb_pkg::rcb_pad_s                      pad_in   [`RCB_NUM_PAIR];
  rcb_pkg::rcb_pad_s                      pad_out  [`RCB_NUM_PAIR];
  logic                                   pad_oe   [`RCB_NUM_PAIR];
  logic                                   ref_clk  [`RCB_NUM_PAIR];
  logic [`RCB_SEL_W-1:0]                  sel_req  [`RCB_NUM_PAIR];
  logic [`RCB_SEL_W-1:0]                  sel      [`RCB_NUM_PAIR];
  logic [`RCB_SEL_W-1:0]                  next_sel [`RCB_NUM_PAIR];

  assign cfg[0]             = pair_a_cfg;
  assign cfg[1]             = pair_b_cfg;
  assign pad_in[0]          = '{pos: pad_a_positive_in, neg: pad_a_negative_in};
  assign pad_in[1]          = '{pos: pad_b_positive_in, neg: pad_b_negative_in};
  assign sel_req[0]         = pair0_select_request;
  assign sel_req[1]         = pair1_select_request;
  assign pad_a_positive_out = pad_out[0].pos;
  assign pad_a_negative_out = pad_out[0].neg;
  assign pad_a_oe           = pad_oe[0];
  assign pad_b_positive_out = pad_out[1].pos;
  assign pad_b_negative_out = pad_out[1].neg;
  assign pad_b_oe           = pad_oe[1];
  assign local_ref_clock_a  = ref_clk[0];
  assign local_ref_clock_b  = ref_clk[1];
  assign pad_pair0_channel_select = sel[0];
  assign pad_pair1_channel_select = sel[1];

  default clocking dflt @(posedge mclk); endclocking
  default disable iff (!resetn);

  genvar i;
  generate
    for (i = 0; i < `RCB_NUM_PAIR; i++) begin : g_pair
      // build-time choices of this pair
      localparam rcb_pkg::rcb_mode_e MODE = (i == 0) ? PAIR_A_MODE : PAIR_B_MODE;
      localparam bit SELECTABLE = (i == 0) ? PAIR_A_SELECTABLE : PAIR_B_SELECTABLE;
      localparam logic [`RCB_SEL_W-1:0] FIXED_CHAN =
        (i == 0) ? PAIR_A_FIXED_CHAN : PAIR_B_FIXED_CHAN;
      localparam logic DRIVE_EXPECT =
        (MODE == rcb_pkg::RCB_MODE_OUTPUT) ? `RCB_DRIVE_OUT : `RCB_DRIVE_IN;

      logic               enabled;
      logic               pad_level;
      logic               chosen;
      logic [`RCB_SEL_W-1:0] mux_sel;
      rcb_pkg::rcb_div_e  div;
      rcb_pkg::rcb_div_e  next_div;
      logic               next_ref;
      logic               next_fab;
      logic               next_oe;
      logic               next_err;
      rcb_pkg::rcb_pad_s  next_pad;

      assign enabled   = resetn & ~cfg[i].buffer_enable_n;
      // differential receiver: true when positive leg above negative
      assign pad_level = pad_in[i].pos & ~pad_in[i].neg;
      assign mux_sel   = SELECTABLE ? sel[i] : FIXED_CHAN;

      rcb_chan_mux u_mux (
        .mclk                  (mclk),
        .resetn                (resetn),
        .recovered_rx_clock    (recovered_rx_clock),
        .buffer_channel_select (mux_sel),
        .chosen_clock          (chosen)
      );

      // next values of the buffer state
      always_comb begin
        next_sel[i] = resetn ? sel_req[i] : `RCB_SEL_RESET;
        next_ref    = 1'b0;
        next_fab    = 1'b0;
        next_div    = rcb_pkg::RCB_DIV_LOW;
        next_oe     = 1'b0;
        next_pad    = '{pos: 1'b0, neg: 1'b0};
        next_err    = resetn & (cfg[i].pad_drive_path_cfg != DRIVE_EXPECT);
        if (MODE == rcb_pkg::RCB_MODE_INPUT) begin
          next_ref = enabled & pad_level;
          // halve on each rising edge of the buffered clock
          next_div = div;
          if (enabled && next_ref && !ref_clk[i]) begin
            next_div = (div == rcb_pkg::RCB_DIV_LOW) ? rcb_pkg::RCB_DIV_HIGH
                                                     : rcb_pkg::RCB_DIV_LOW;
          end
          if (!enabled) begin
            next_div = rcb_pkg::RCB_DIV_LOW;
          end
          unique case (cfg[i].fabric_out_config)
            `RCB_FAB_PASS: next_fab = next_ref;
            `RCB_FAB_DIV2: next_fab = (next_div == rcb_pkg::RCB_DIV_HIGH);
            `RCB_FAB_ZERO: next_fab = 1'b0;
            `RCB_FAB_RSVD: next_fab = 1'b0; // reserved held quiet
          endcase
          next_err = next_err | (resetn & (cfg[i].fabric_out_config == `RCB_FAB_RSVD));
        end else begin
          next_oe  = enabled;
          // true on positive, complement on negative
          next_pad = '{pos: enabled & chosen, neg: enabled & ~chosen};
        end
      end

      // state registers, cleared by synchronous reset
      always_ff @(posedge mclk) begin
        ref_clk[i]          <= next_ref;
        fabric_clock_out[i] <= next_fab;
        div                 <= next_div;
        pad_oe[i]           <= next_oe;
        pad_out[i]          <= next_pad;
        cfg_error[i]        <= next_err;
        sel[i]              <= next_sel[i];
      end

      // rising edge of the reference; the halved output toggles in the same cycle
      sequence s_ref_rise;
        ref_clk[i] && !$past(ref_clk[i]);
      endsequence

      a_enable_stops_out: assert property (
        $past(cfg[i].buffer_enable_n) && $past(resetn) |->
          !ref_clk[i] && !pad_oe[i] && !pad_out[i].pos && !pad_out[i].neg)
        else $error("disabled buffer still drives a clock");

      a_direction_fixed: assert property (
        (MODE == rcb_pkg::RCB_MODE_INPUT) |-> !pad_oe[i] && !pad_out[i].pos && !pad_out[i].neg)
        else $error("input pair drives its pads");

      if (MODE == rcb_pkg::RCB_MODE_INPUT) begin : g_in_chk
        a_ref_follows_pad: assert property (
          $past(resetn) |-> ref_clk[i] == $past(enabled & pad_level))
          else $error("local reference does not follow pad");
        a_div_halves: assert property (
          $past(resetn) && $past(enabled) &&
          $past(cfg[i].fabric_out_config) == `RCB_FAB_DIV2 &&
          $past(cfg[i].fabric_out_config, 2) == `RCB_FAB_DIV2 ##0 s_ref_rise |->
            fabric_clock_out[i] != $past(fabric_clock_out[i]))
          else $error("halved output missed a toggle");
        a_zero_hold: assert property (
          $past(cfg[i].fabric_out_config) == `RCB_FAB_ZERO |-> !fabric_clock_out[i])
          else $error("fabric output not held at zero");
      end else begin : g_out_chk
        a_output_follows: assert property (
          $past(enabled) |-> pad_oe[i] && pad_out[i].pos == $past(chosen))
          else $error("pad does not carry the chosen recovered clock");
        a_pads_differential: assert property (
          pad_oe[i] |-> pad_out[i].neg == !pad_out[i].pos)
          else $error("pads not true and complement");
      end

      a_select_route: assert property (
        $past(resetn) |-> sel[i] == $past(sel_req[i]))
        else $error("select output does not follow its request");
    end
  endgenerate

endmodule

// [sim/rcb_far_end.sv]
// external reference clock source facing pad pair a
// assumes the device samples the pads on mclk; source is mclk-aligned
`timescale 1ns/100ps

module rcb_far_end #(
  parameter int HALF = 3
) (
  // clock and control
  input  wire logic mclk,
  input  wire logic run,
  // differential pad pair
  output logic      pad_pos,
  output logic      pad_neg
);
  int cnt;

  // outside clock on pads
  // stands low when stopped so a stale high never looks like a clock
  always_ff @(posedge mclk) begin
    if (!run) begin
      cnt <= 0;
      pad_pos <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      pad_pos <= ~pad_pos;
    end else begin
      cnt <= cnt + 1;
    end
  end

  // complement leg always opposite the true leg
  assign pad_neg = ~pad_pos;
endmodule

// [sim/rcb_top_bench.sv]
// self-checking bench for the reference clock pad buffers
// assumes rcb_top defaults: pair a input mode, pair b output mode, both selectable
`timescale 1ns/100ps

module rcb_top_bench;
  logic                   mclk;
  logic                   resetn;
  rcb_pkg::rcb_pair_cfg_s pair_a_cfg;
  rcb_pkg::rcb_pair_cfg_s pair_b_cfg;
  logic [1:0]             req0;
  logic [1:0]             req1;
  logic [3:0]             rec;
  logic                   run;
  logic                   pa_p;
  logic                   pa_n;
  logic                   pb_p;
  logic                   pb_n;
  logic                   pa_oe;
  logic                   pb_oe;
  logic                   pa_po;
  logic                   pa_no;
  logic                   pf_p;
  logic                   pf_n;
  logic                   pf_oe;
  logic                   ref_a;
  logic                   ref_b;
  logic [1:0]             fab;
  logic [1:0]             sel0;
  logic [1:0]             sel1;
  logic [1:0]             cerr;
  int                     err_total;
  int                     compares;

  // 10 MHz clock
  initial mclk = 1'b0;
  always #50 mclk = ~mclk;

  rcb_far_end rcb_far_end_i (.mclk(mclk), .run(run), .pad_pos(pa_p), .pad_neg(pa_n));

  // pad b wire sits low when nobody drives it
  // selectable buffers take the common block selects
  rcb_top rcb_top_i (
    .mclk(mclk), .resetn(resetn), .pair_a_cfg(pair_a_cfg), .pair_b_cfg(pair_b_cfg),
    .pair0_select_request(req0), .pair1_select_request(req1), .recovered_rx_clock(rec),
    .pad_a_positive_in(pa_p), .pad_a_negative_in(pa_n), .pad_a_positive_out(pa_po),
    .pad_a_negative_out(pa_no), .pad_a_oe(pa_oe), .pad_b_positive_in(pb_oe & pb_p),
    .pad_b_negative_in(pb_oe & pb_n), .pad_b_positive_out(pb_p), .pad_b_negative_out(pb_n),
    .pad_b_oe(pb_oe), .local_ref_clock_a(ref_a), .local_ref_clock_b(ref_b),
    .fabric_clock_out(fab), .pad_pair0_channel_select(sel0),
    .pad_pair1_channel_select(sel1), .cfg_error(cerr));

  // fixed-source buffer on pair b, channel 2 by parameter, selects ignored
  rcb_top #(.PAIR_B_SELECTABLE(1'b0), .PAIR_B_FIXED_CHAN(2'h2)) rcb_top_fixed_i (
    .mclk(mclk), .resetn(resetn), .pair_a_cfg(pair_a_cfg), .pair_b_cfg(pair_b_cfg),
    .pair0_select_request(req0), .pair1_select_request(req1), .recovered_rx_clock(rec),
    .pad_a_positive_in(pa_p), .pad_a_negative_in(pa_n), .pad_a_positive_out(),
    .pad_a_negative_out(), .pad_a_oe(), .pad_b_positive_in(1'b0),
    .pad_b_negative_in(1'b0), .pad_b_positive_out(pf_p), .pad_b_negative_out(pf_n),
    .pad_b_oe(pf_oe), .local_ref_clock_a(), .local_ref_clock_b(),
    .fabric_clock_out(), .pad_pair0_channel_select(),
    .pad_pair1_channel_select(), .cfg_error());

  // one comparison, reported at once on mismatch
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask

  // advance n edges, then settle past them
  task step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // every fabric code on the input pair, clock running
  task t_input;
    logic lvl;
    logic prv;
    logic dv;
    for (int c = 0; c < 4; c++) begin
      pair_a_cfg = '{1'b1, c[1:0], 1'b0};
      step(2);
      dv = 1'b0;
      prv = 1'b0;
      pair_a_cfg.buffer_enable_n = 1'b0;
      repeat (9) begin
        lvl = pa_p & ~pa_n;
        step(1);
        if (lvl && !prv) dv = ~dv;
        chk(ref_a, lvl);
        chk(fab[0], c == 0 ? lvl : (c == 1 ? dv : 1'b0));
        chk(cerr[0], c == 3);
        chk({pa_oe, pa_po, pa_no}, 3'h0);
        prv = lvl;
      end
    end
    $display("test input_codes done");
  endtask

  // buffer_enable_n high stops both input clocks
  task t_disable;
    pair_a_cfg = '{1'b1, 2'h0, 1'b0};
    repeat (6) begin
      step(1);
      chk({ref_a, fab[0]}, 2'h0);
    end
    $display("test input_disable done");
  endtask

  // each channel chosen in turn, others held opposite
  task t_output;
    for (int s = 0; s < 4; s++) begin
      req1 = s[1:0];
      req0 = 2'h3 - s[1:0];
      // bus bit n carries channel n
      rec = 4'h1 << s;
      step(4);
      chk(sel1, s);
      chk(sel0, 3 - s);
      chk({pb_oe, pb_p, pb_n}, 3'h6);
      chk({ref_b, fab[1]}, 2'h0);
      chk({pf_oe, pf_p, pf_n}, s == 2 ? 3'h6 : 3'h5);
      rec = ~(4'h1 << s);
      step(3);
      chk({pb_p, pb_n}, 2'h1);
      chk({pf_p, pf_n}, s == 2 ? 2'h1 : 2'h2);
    end
    $display("test output_select done");
  endtask

  // drive path mismatch, then output buffer disabled
  task t_out_fault;
    pair_b_cfg = '{1'b0, 2'h0, 1'b0};
    step(2);
    chk(cerr[1], 1'b1);
    pair_b_cfg = '{1'b1, 2'h0, 1'b1};
    step(2);
    chk({cerr[1], pb_oe, pb_p, pb_n}, 4'h0);
    chk({pf_oe, pf_p, pf_n}, 3'h0);
    $display("test output_fault done");
  endtask

  // reset in mid-run clears every output, selects return after release
  task t_reset;
    req0 = 2'h1;
    req1 = 2'h2;
    resetn = 1'b0;
    step(2);
    chk({ref_a, fab, pa_oe, pb_oe, pb_p, pb_n}, 7'h00);
    chk({sel0, sel1, cerr}, 6'h00);
    resetn = 1'b1;
    step(2);
    chk({sel0, sel1}, 4'h6);
    chk(pb_oe, 1'b1);
    $display("test midrun_reset done");
  endtask

  // verdict and end of run
  task wrap_up;
    $display("compares=%0d mismatches=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    err_total = 0;
    compares = 0;
    resetn = 1'b0;
    run = 1'b0;
    req0 = 2'h0;
    req1 = 2'h0;
    rec = 4'h0;
    pair_a_cfg = '{1'b1, 2'h0, 1'b0};
    pair_b_cfg = '{1'b0, 2'h0, 1'b1};
    repeat (12) @(posedge mclk);
    #1;
    resetn = 1'b1;
    run = 1'b1;
    t_input;
    t_disable;
    t_output;
    t_reset;
    t_out_fault;
    wrap_up;
  end
endmodule
